// *** logic/rfss_pkg.sv ***
// Constants for the reset filter and startup sequencer
// Function
// - Reset pin low pulses under 5us ignored, over 9us full reset, between may start.
// - Spike rejection keeps working while a valid reset is held low.
// - Reset in sleep-out runs blanking up to 120 ms; in sleep-in stays blank.
// - After the reset period every setting returns to its reset default; here sleep_state_r is held at it only in HOLD, then follows sleep_in.
// - System clock comes from an internal 100 MHz oscillator, not observable outside.
package rfss_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int REJECT_NS       = 5_000;
    localparam int ACCEPT_NS       = 9_000;
    localparam int CMD_WAIT_MS     = 10;
    localparam int SLEEP_EXIT_WAIT_MS = 120;
    localparam int BLANK_MAX_MS    = 120;
    localparam int GLITCH_NS       = 1_000;
    // Least ns times round up; the ms waits truncate cycles per ms
    localparam int REJECT_CYC  = (REJECT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ACCEPT_CYC  = (ACCEPT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int GLITCH_CYC  = (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CMD_WAIT_CYC    = CMD_WAIT_MS * (CLK_HZ / 1000);
    localparam int SLEEP_EXIT_WAIT_CYC = SLEEP_EXIT_WAIT_MS * (CLK_HZ / 1000);
    // Longest time rounds down
    localparam int BLANK_MAX_CYC   = BLANK_MAX_MS * (CLK_HZ / 1000);

    localparam logic SLEEP_RST_VAL = 1'b1;

    typedef enum logic [1:0] {
        RFSS_RUN   = 2'b00,
        RFSS_HOLD  = 2'b01,
        RFSS_BLANK = 2'b10,
        RFSS_WAIT  = 2'b11
    } rfss_state_type;

endpackage

// *** logic/rfss_top.sv ***
// Reset pin filter, blanking and post-reset wait sequencer
`timescale 1ns/1ns
module rfss_top
    import rfss_pkg::*;
#(
    parameter int BLANK_CYC      = BLANK_MAX_CYC,
    parameter int CMD_CYC        = CMD_WAIT_CYC,
    parameter int SLEEP_EXIT_CYC = SLEEP_EXIT_WAIT_CYC,
    parameter int CW             = 24
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic hw_reset_n,
    input  wire logic sleep_in,
    input  wire logic blank_done,
    output logic      core_reset_r,
    output logic      blank_r,
    output logic      blank_seq_r,
    output logic      cmd_ready_r,
    output logic      sleep_exit_ok_r,
    output logic      sleep_state_r
);

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    // Three stages; a level counts once stages two and three agree
    logic [2:0] sync_r;
    logic       pin_low_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_r    <= 3'h7;
            pin_low_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], hw_reset_n};
            if (sync_r[1] == sync_r[2]) begin
                pin_low_r <= ~sync_r[2];
            end
        end
    end

    // ----------------------------------------
    // Pulse width classifier
    // ----------------------------------------
    // Counts low time; during a held reset, a high blip shorter than the
    // glitch window is ignored so the reset stays in force
    logic [15:0] low_cnt_r;
    logic [15:0] high_cnt_r;
    logic        accepted_r;
    logic        start_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_cnt_r  <= 16'h0000;
            high_cnt_r <= 16'h0000;
            accepted_r <= 1'b0;
            start_r    <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (pin_low_r) begin
                high_cnt_r <= 16'h0000;
                if (low_cnt_r != 16'hFFFF) begin
                    low_cnt_r <= low_cnt_r + 16'h0001;
                end
                // A full reset starts once the low time reaches the reject limit; the accept limit plays no part here
                if (!accepted_r && low_cnt_r == 16'(REJECT_CYC - 1)) begin
                    accepted_r <= 1'b1;
                    start_r    <= 1'b1;
                end
            end else if (accepted_r && high_cnt_r < 16'(GLITCH_CYC - 1)) begin
                high_cnt_r <= high_cnt_r + 16'h0001;
            end else begin
                low_cnt_r  <= 16'h0000;
                high_cnt_r <= 16'h0000;
                accepted_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    rfss_state_type state_r;
    logic [CW-1:0]  tmr_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r     <= RFSS_WAIT;
            tmr_r       <= '0;
            blank_seq_r <= 1'b0;
        end else if (start_r) begin
            state_r     <= RFSS_HOLD;
            tmr_r       <= '0;
            // Only a panel that is lit needs the blanking run
            blank_seq_r <= ~sleep_state_r;
        end else begin
            unique case (state_r)
                RFSS_RUN: begin
                    tmr_r <= tmr_r;
                end
                RFSS_HOLD: begin
                    // Saturate one short of the limit: a long hold ends blanking at once
                    if (blank_seq_r && tmr_r != CW'(BLANK_CYC - 1)) begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                    if (!accepted_r) begin
                        state_r <= blank_seq_r ? RFSS_BLANK : RFSS_WAIT;
                    end
                end
                RFSS_BLANK: begin
                    // Bounded even if the panel never reports done
                    if (blank_done || tmr_r >= CW'(BLANK_CYC - 1)) begin
                        state_r     <= RFSS_WAIT;
                        blank_seq_r <= 1'b0;
                        tmr_r       <= '0;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
                RFSS_WAIT: begin
                    blank_seq_r <= 1'b0;
                    if (tmr_r == CW'(SLEEP_EXIT_CYC - 1)) begin
                        state_r <= RFSS_RUN;
                    end else begin
                        tmr_r <= tmr_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_reset_r    <= 1'b1;
            blank_r         <= 1'b1;
            cmd_ready_r     <= 1'b0;
            sleep_exit_ok_r <= 1'b0;
            sleep_state_r   <= SLEEP_RST_VAL;
        end else begin
            core_reset_r    <= (state_r == RFSS_HOLD) || (state_r == RFSS_BLANK);
            blank_r         <= (state_r != RFSS_RUN) || sleep_in;
            cmd_ready_r     <= (state_r == RFSS_RUN)
                               || (state_r == RFSS_WAIT && tmr_r >= CW'(CMD_CYC - 1));
            sleep_exit_ok_r <= (state_r == RFSS_RUN);
            // Settings fall back to default (sleep-in) while reset is applied
            if (state_r == RFSS_HOLD) begin
                sleep_state_r <= SLEEP_RST_VAL;
            end else begin
                sleep_state_r <= sleep_in;
            end
        end
    end

    // ----------------------------------------
    // Check helpers
    // ----------------------------------------
    // Cycles since the core reset last dropped; the host waits are measured
    // from here, which already trails the pin release by the glitch window
    logic [CW-1:0] quiet_cnt_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            quiet_cnt_r <= '0;
        end else if (core_reset_r) begin
            quiet_cnt_r <= '0;
        end else if (quiet_cnt_r != '1) begin
            quiet_cnt_r <= quiet_cnt_r + 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_short_reject: assert property (@(posedge ref_clk) disable iff (rst)
        !accepted_r && low_cnt_r < 16'(REJECT_CYC - 1) |=> !accepted_r)
        else $error("short low pulse accepted");
    chk_full_reset: assert property (@(posedge ref_clk) disable iff (rst)
        pin_low_r && low_cnt_r == 16'(ACCEPT_CYC) |-> accepted_r)
        else $error("long low pulse not accepted");
    chk_reject_clear: assert property (@(posedge ref_clk) disable iff (rst)
        !pin_low_r && !accepted_r |=> low_cnt_r == 16'h0000)
        else $error("rejected pulse left count behind");
    chk_accept_time: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(accepted_r) |-> low_cnt_r == 16'(REJECT_CYC))
        else $error("reset accepted at wrong width");
    chk_spike_hold: assert property (@(posedge ref_clk) disable iff (rst)
        accepted_r && !pin_low_r && high_cnt_r < 16'(GLITCH_CYC - 1) |=> accepted_r)
        else $error("spike broke held reset");
    chk_blank_sel: assert property (@(posedge ref_clk) disable iff (rst)
        start_r |=> blank_seq_r == ~$past(sleep_state_r))
        else $error("blank sequence choice wrong");
    chk_blank_bound: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == RFSS_BLANK |-> tmr_r < CW'(BLANK_CYC))
        else $error("blanking too long");
    chk_blank_done: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == RFSS_BLANK && blank_done && !start_r |=> state_r == RFSS_WAIT)
        else $error("blanking not ended on done");
    chk_reset_core: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == RFSS_HOLD |=> core_reset_r && blank_r)
        else $error("core not reset during hold");
    chk_default_sleep: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == RFSS_HOLD |=> sleep_state_r == SLEEP_RST_VAL)
        else $error("settings not defaulted");
    chk_cmd_gate: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(cmd_ready_r) |-> quiet_cnt_r >= CW'(CMD_CYC - 1))
        else $error("command ready early");
    chk_sleep_gate: assert property (@(posedge ref_clk) disable iff (rst)
        sleep_exit_ok_r |-> cmd_ready_r)
        else $error("sleep exit before command ready");
    chk_sleep_wait: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(sleep_exit_ok_r) |-> quiet_cnt_r >= CW'(SLEEP_EXIT_CYC - 1))
        else $error("sleep exit allowed early");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    cov_reset_start: cover property (@(posedge ref_clk) disable iff (rst) start_r);
    cov_blank_done: cover property (@(posedge ref_clk) disable iff (rst)
        state_r == RFSS_BLANK && blank_done);
    cov_blank_run: cover property (@(posedge ref_clk) disable iff (rst) state_r == RFSS_BLANK);
    cov_run_reached: cover property (@(posedge ref_clk) disable iff (rst) $rose(sleep_exit_ok_r));
    cov_spike: cover property (@(posedge ref_clk) disable iff (rst)
        accepted_r && !pin_low_r);

endmodule

// *** verif/rfss_host_model.sv ***
// Host side model that drives the hardware reset pin
`timescale 1ns/1ns
module rfss_host_model (
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [15:0] low_cyc,
    input  wire logic [15:0] spike_at,
    output logic             busy,
    output logic             hw_reset_n
);
    // ----------------------------------------
    // Reset pulse driver
    // ----------------------------------------
    // Pin idles high; the bench applies rst first, then commands each pulse through go
    // Only the reset pin is driven; no display memory write cycle is issued
    initial begin
        hw_reset_n = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go) begin
                busy <= 1'b1;
                for (int i = 0; i < low_cyc; i++) begin
                    @(negedge ref_clk);
                    // 50 cycle high blip models an ESD spike
                    hw_reset_n = (spike_at != 0) && (i >= spike_at) && (i < spike_at + 50);
                end
                @(negedge ref_clk);
                hw_reset_n = 1'b1;
                busy = 1'b0;
            end
        end
    end
endmodule

// *** verif/rfss_top_test.sv ***
// Self-checking bench for the reset filter and startup sequencer
`timescale 1ns/1ns
module rfss_top_test
    import rfss_pkg::*;
;
    localparam int BLANK_C = 2000;
    localparam int CMD_C   = 20;
    localparam int SLP_C   = 40;
    logic        ref_clk, rst, sleep_in, blank_done, go, busy, hw_reset_n;
    logic        core_reset_r, blank_r, blank_seq_r, cmd_ready_r, sleep_exit_ok_r;
    logic        sleep_state_r, saw_rst, saw_drop, saw_blank, saw_seq;
    logic [15:0] low_cyc, spike_at;
    int          err_total, compares, seed, w, mon_id, pulse_id;

    rfss_top #(.BLANK_CYC(BLANK_C), .CMD_CYC(CMD_C), .SLEEP_EXIT_CYC(SLP_C)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n), .sleep_in(sleep_in),
        .blank_done(blank_done), .core_reset_r(core_reset_r), .blank_r(blank_r),
        .blank_seq_r(blank_seq_r), .cmd_ready_r(cmd_ready_r),
        .sleep_exit_ok_r(sleep_exit_ok_r), .sleep_state_r(sleep_state_r));
    rfss_host_model host_u (.ref_clk(ref_clk), .go(go), .low_cyc(low_cyc),
        .spike_at(spike_at), .busy(busy), .hw_reset_n(hw_reset_n));

    // Bench clock stands in for the internal oscillator; no outside test clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Monitor, checks and waits
    // ----------------------------------------
    always @(posedge ref_clk) begin
        // A new pulse clears the flags here, so only this process writes them
        if (mon_id != pulse_id) begin
            {saw_rst, saw_drop, saw_blank, saw_seq} = 4'h0;
            mon_id = pulse_id;
        end
        if (busy && saw_rst && core_reset_r === 1'b0) saw_drop = 1'b1;
        saw_rst = saw_rst | core_reset_r;
        saw_blank = saw_blank | blank_r;
        saw_seq = saw_seq | blank_seq_r;
    end
    // Margin of 10 cycles covers the synchroniser latency
    function automatic logic exp_accept(int width);
        return width >= REJECT_CYC + 10;
    endfunction
    task automatic chk(logic got, logic exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wait_sig(int sel, int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((sel == 0 && core_reset_r === 1'b0) || (sel == 1 && cmd_ready_r === 1'b1)
                || (sel == 2 && busy === 1'b0)) break;
            @(negedge ref_clk);
        end
        if (i == lim) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic pulse(int width, int spike);
        low_cyc = width[15:0];
        spike_at = spike[15:0];
        pulse_id++;
        go = 1'b1;
        @(negedge ref_clk);
        go = 1'b0;
        wait_sig(2, width + 20);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {err_total, compares, seed} = {32'h0, 32'h0, 32'h48};
        {rst, sleep_in, blank_done, go, low_cyc, spike_at} = {4'hC, 32'h0};
        repeat (10) @(negedge ref_clk);
        chk(sleep_state_r, 1'b1);
        rst = 1'b0;
        repeat (CMD_C - 5) @(negedge ref_clk);
        chk(cmd_ready_r, 1'b0);
        repeat (10) @(negedge ref_clk);
        chk(cmd_ready_r, 1'b1);
        chk(sleep_exit_ok_r, 1'b0);
        repeat (SLP_C) @(negedge ref_clk);
        chk(sleep_exit_ok_r, 1'b1);
        for (int k = 0; k < 6; k++) begin
            w = (k == 0) ? 480 : 20 + ($unsigned($random(seed)) % 380);
            pulse(w, 0);
            repeat (10) @(negedge ref_clk);
            chk(saw_rst, exp_accept(w));
            chk(cmd_ready_r, 1'b1);
        end
        for (int k = 0; k < 2; k++) begin
            sleep_in = (k == 0);
            w = 950 + ($unsigned($random(seed)) % 200);
            pulse(w, 600);
            chk(saw_rst, exp_accept(w));
            chk(saw_drop, 1'b0);
            chk(saw_blank, 1'b1);
            // Past the glitch window: a lit panel is still blanking
            repeat (GLITCH_CYC + 10) @(negedge ref_clk);
            chk(core_reset_r, !sleep_in);
            blank_done = 1'b1;
            @(negedge ref_clk);
            blank_done = 1'b0;
            wait_sig(0, 10);
            chk(cmd_ready_r, 1'b0);
            chk(saw_seq, !sleep_in);
            wait_sig(1, CMD_C + 10);
            repeat (SLP_C) @(negedge ref_clk);
            chk(sleep_exit_ok_r, 1'b1);
            chk(blank_r, sleep_in);
        end
        complete_run();
    end
endmodule
